// ---- stwrp_params.svh ----
// Command codes, field positions, reset values and timing counts of the register port
`ifndef STWRP_PARAMS_SVH
`define STWRP_PARAMS_SVH
`define STWRP_CMD_DIVIDER 8'h01
`define STWRP_CMD_ROUTING 8'h02
`define STWRP_CMD_TUNING 8'h08
`define STWRP_CMD_BUS_ID 8'h0d
`define STWRP_CMD_BAND 8'h0e
`define STWRP_CMD_RANGE 8'h37
`define STWRP_CMD_COMMIT 8'h3f
`define STWRP_WC_BIT 3
`define STWRP_RST_TUNING 10'h1f4
`define STWRP_RST_DIVIDER 10'h000
`define STWRP_RST_ROUTING 10'h060
`define STWRP_RST_BUS_ID 5'h00
// Arbitrary device type code
`define STWRP_DEV_TYPE 4'h5
`define STWRP_FACTORY_BAND 5'h10
`define STWRP_NV_WRITE_TIME_US 10000
`define STWRP_CLK_MHZ 20
`define STWRP_NV_WRITE_CYCLES (`STWRP_NV_WRITE_TIME_US * `STWRP_CLK_MHZ)
`endif

// ---- stwrp_pkg.sv ----
// Types shared by the two-wire register port and its nonvolatile store
package stwrp_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
  } stwrp_state_e;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    stwrp_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] hold;
    logic [7:0] cmd;
    logic [1:0] bytecnt;
    logic rw;
    logic nack;
    logic wrote;
    logic addr_wrote;
    logic commit_reg;
    logic commit_cmd;
    logic commit_addr;
    logic sda_oe;
    logic sda_out;
    logic [9:0] tuning;
    logic [4:0] band;
    logic [9:0] divider;
    logic [9:0] routing;
    logic [4:0] bus_id;
  } stwrp_core_s;

  typedef struct packed {
    logic busy;
    logic [17:0] count;
    logic [9:0] tuning;
    logic [4:0] band;
    logic [9:0] divider;
    logic [9:0] routing;
    logic [4:0] bus_id;
  } stwrp_nv_s;
endpackage

// ---- stwrp_nv_store.sv ----
// Nonvolatile image of the registers with its write-cycle busy timer
`timescale 1ns/1ps
`default_nettype none
`include "stwrp_params.svh"
module stwrp_nv_store import stwrp_pkg::*; #(
  parameter int NV_WRITE_CYCLES = `STWRP_NV_WRITE_CYCLES,
  parameter logic [4:0] FACTORY_BAND = `STWRP_FACTORY_BAND
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic commit_reg,
  input wire logic commit_cmd,
  input wire logic commit_addr,
  input wire logic [9:0] tuning,
  input wire logic [4:0] band,
  input wire logic [9:0] divider,
  input wire logic [9:0] routing,
  input wire logic [4:0] bus_id,
  output logic busy,
  output logic [9:0] nv_tuning,
  output logic [4:0] nv_band,
  output logic [9:0] nv_divider,
  output logic [9:0] nv_routing,
  output logic [4:0] nv_bus_id
);
  stwrp_nv_s st;
  stwrp_nv_s next_st;

  always_comb begin
    next_st = st;
    if (st.busy) begin
      next_st.count = st.count + 18'h1;
      if (st.count == 18'(NV_WRITE_CYCLES - 1)) begin
        next_st.busy = 1'b0;
      end
    end
    if (commit_reg) begin
      next_st.tuning = tuning;
      next_st.band = band;
      next_st.divider = divider;
      next_st.routing = routing;
    end
    // commit command copies divider and routing only
    if (commit_cmd) begin
      next_st.divider = divider;
      next_st.routing = routing;
    end
    if (commit_addr) begin
      next_st.bus_id = bus_id;
    end
    if (commit_reg || commit_cmd || commit_addr) begin
      next_st.busy = 1'b1;
      next_st.count = 18'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{busy: 1'b0, count: 18'h0, tuning: `STWRP_RST_TUNING, band: FACTORY_BAND,
              divider: `STWRP_RST_DIVIDER, routing: `STWRP_RST_ROUTING,
              bus_id: `STWRP_RST_BUS_ID};
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign nv_tuning = st.tuning;
  assign nv_band = st.band;
  assign nv_divider = st.divider;
  assign nv_routing = st.routing;
  assign nv_bus_id = st.bus_id;
endmodule
`default_nettype wire

// ---- stwrp_port.sv ----
// Two-wire slave register port of the oscillator with nonvolatile commit policy
// Behaviour
// - Three low address-byte bits select the bus address; reset value zero.
// - With commit_on_command clear, every register write commits to nonvolatile store.
// - With commit_on_command set, command 3Fh alone commits divider and routing words.
// - Writing the address byte always commits it, whatever commit_on_command holds.
// - Command 37h reads the range register, two bytes, band value in top bits.
// - Write is address with direction 0, command byte, data; address and command acknowledged.
// - Command 08h: tuning code, eight high bits, then two low bits on top.
// - Command 0Eh: offset in five low bits; upper three read as ones.
// - Command 01h: divider word, high byte first, two low bits on top.
// - Command 02h: routing word, high byte first, two low bits on top.
// - Command 0Dh: five-bit address byte; upper three bits ignored, read zero.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - Transmitter changes SDA only while SCL low; stable while SCL high.
// - Eight-bit bytes, each acknowledged in a ninth bit; byte count unlimited.
// - Works at both 100 kHz and 400 kHz bus rates.
// - Acknowledger holds SDA low through the high phase of the ninth clock.
// - While the nonvolatile write runs, the address byte is not acknowledged.
// - Master NACKs the last read byte; device then releases SDA.
// - Transfer ends with STOP or repeated START; repeated START begins next transfer.
// - Address recognised after direction bit; direction 1 makes device transmit.
// - Acknowledge address only when type code and three select bits match.
// - After new select bits are written, respond only to the new address.
`timescale 1ns/1ps
`default_nettype none
`include "stwrp_params.svh"
module stwrp_port import stwrp_pkg::*; #(
  parameter int NV_WRITE_CYCLES = `STWRP_NV_WRITE_CYCLES,
  parameter logic [4:0] FACTORY_BAND = `STWRP_FACTORY_BAND
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [9:0] tuning_code,
  output logic [4:0] band_offset,
  output logic [9:0] divider_word,
  output logic [9:0] output_routing_word,
  output logic [4:0] bus_id,
  output logic nv_busy,
  output logic [9:0] nv_tuning,
  output logic [4:0] nv_band,
  output logic [9:0] nv_divider,
  output logic [9:0] nv_routing,
  output logic [4:0] nv_bus_id
);
  stwrp_core_s st;
  stwrp_core_s next_st;
  logic busy;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic commit_on_command;
  logic [7:0] rd_first;
  logic [7:0] rd_next;

  // Byte the device sends for a command at a given byte index
  function automatic logic [7:0] rd_byte(input logic [7:0] cmd, input logic [1:0] idx,
                                         input stwrp_core_s s);
    logic [9:0] word;
    word = 10'h000;
    rd_byte = 8'hff;
    unique case (cmd)
      `STWRP_CMD_TUNING: word = s.tuning;
      `STWRP_CMD_DIVIDER: word = s.divider;
      `STWRP_CMD_ROUTING: word = s.routing;
      default: word = 10'h000;
    endcase
    case (cmd)
      // tuning, divider or routing word: high byte then low bits
      `STWRP_CMD_TUNING, `STWRP_CMD_DIVIDER, `STWRP_CMD_ROUTING: begin
        if (idx == 2'd0) begin
          rd_byte = word[9:2];
        end else begin
          rd_byte = {word[1:0], 6'h00};
        end
      end
      // upper offset bits read as ones
      `STWRP_CMD_BAND: rd_byte = {3'b111, s.band};
      // upper address bits read as zero
      `STWRP_CMD_BUS_ID: rd_byte = {3'b000, s.bus_id};
      // band value in the top five bits of the first byte
      `STWRP_CMD_RANGE: begin
        if (idx == 2'd0) begin
          rd_byte = {FACTORY_BAND, 3'b000};
        end else begin
          rd_byte = 8'h00;
        end
      end
      default: rd_byte = 8'hff;
    endcase
  endfunction

  // two-flop sampling leaves over ten clocks of margin in a fast-mode high phase
  assign scl_rise = st.scl_s2 & ~st.scl_d;
  assign scl_fall = ~st.scl_s2 & st.scl_d;
  // bus conditions from SDA edges while SCL stays high
  assign start_det = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
  assign stop_det = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;
  assign commit_on_command = st.bus_id[`STWRP_WC_BIT];
  assign rd_first = rd_byte(st.cmd, 2'd0, st);
  assign rd_next = rd_byte(st.cmd, st.bytecnt, st);

  always_comb begin
    next_st = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;
    next_st.sda_out = 1'b0;
    next_st.commit_reg = 1'b0;
    next_st.commit_cmd = 1'b0;
    next_st.commit_addr = 1'b0;
    // STOP or repeated START both close a transfer
    if (start_det || stop_det) begin
      // automatic commit once the write command is complete
      if (st.wrote && !commit_on_command) begin
        next_st.commit_reg = 1'b1;
      end
      // address byte committed regardless of the control bit
      if (st.addr_wrote) begin
        next_st.commit_addr = 1'b1;
      end
      next_st.wrote = 1'b0;
      next_st.addr_wrote = 1'b0;
      next_st.sda_oe = 1'b0;
      next_st.bitcnt = 4'h0;
      next_st.state = start_det ? S_ADDR : S_IDLE;
    end else begin
      unique case (st.state)
        S_IDLE: begin
          next_st.sda_oe = 1'b0;
        end
        // eight bits shifted in on rising SCL, acknowledged in the ninth
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise && st.bitcnt != 4'h8) begin
            next_st.shreg = {st.shreg[6:0], st.sda_s2};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h0;
            // pull SDA low for the whole ninth pulse
            next_st.sda_oe = 1'b1;
            unique case (st.state)
              S_ADDR: begin
                // type code and select bits must both match
                // compared against the live address byte
                // refuse while the store is busy
                if (st.shreg[7:1] == {`STWRP_DEV_TYPE, st.bus_id[2:0]} && !busy) begin
                  next_st.rw = st.shreg[0];
                  next_st.state = S_ADDR_ACK;
                end else begin
                  next_st.sda_oe = 1'b0;
                  next_st.state = S_IDLE;
                end
              end
              S_CMD: begin
                next_st.cmd = st.shreg;
                next_st.bytecnt = 2'd0;
                next_st.state = S_CMD_ACK;
                if (st.shreg == `STWRP_CMD_COMMIT && commit_on_command) begin
                  next_st.commit_cmd = 1'b1;
                end
              end
              default: begin
                next_st.state = S_WDATA_ACK;
                if (st.bytecnt != 2'd3) begin
                  next_st.bytecnt = st.bytecnt + 2'd1;
                end
                if (st.bytecnt == 2'd0) begin
                  next_st.hold = st.shreg;
                end
                case (st.cmd)
                  // tuning code taken on its second byte
                  `STWRP_CMD_TUNING: begin
                    if (st.bytecnt == 2'd1) begin
                      next_st.tuning = {st.hold, st.shreg[7:6]};
                      next_st.wrote = 1'b1;
                    end
                  end
                  // divider word taken on its second byte
                  `STWRP_CMD_DIVIDER: begin
                    if (st.bytecnt == 2'd1) begin
                      next_st.divider = {st.hold, st.shreg[7:6]};
                      next_st.wrote = 1'b1;
                    end
                  end
                  // routing word taken on its second byte
                  `STWRP_CMD_ROUTING: begin
                    if (st.bytecnt == 2'd1) begin
                      next_st.routing = {st.hold, st.shreg[7:6]};
                      next_st.wrote = 1'b1;
                    end
                  end
                  // only the five low bits are kept
                  `STWRP_CMD_BAND: begin
                    if (st.bytecnt == 2'd0) begin
                      next_st.band = st.shreg[4:0];
                      next_st.wrote = 1'b1;
                    end
                  end
                  // upper three bits of the byte dropped
                  // select bits land in the low three positions
                  `STWRP_CMD_BUS_ID: begin
                    if (st.bytecnt == 2'd0) begin
                      next_st.bus_id = st.shreg[4:0];
                      next_st.wrote = 1'b1;
                      next_st.addr_wrote = 1'b1;
                    end
                  end
                  // unknown or read-only command, data acknowledged then dropped
                  default: begin
                    next_st.wrote = st.wrote;
                  end
                endcase
              end
            endcase
          end
        end
        // direction bit decides between transmit and command reception
        S_ADDR_ACK: begin
          if (scl_fall) begin
            if (st.rw) begin
              next_st.sda_oe = ~rd_first[7];
              next_st.shreg = {rd_first[6:0], 1'b0};
              next_st.bytecnt = 2'd1;
              next_st.bitcnt = 4'h1;
              next_st.state = S_RDATA;
            end else begin
              next_st.sda_oe = 1'b0;
              next_st.state = S_CMD;
            end
          end
        end
        // command and data acknowledged, then released for the next byte
        S_CMD_ACK, S_WDATA_ACK: begin
          if (scl_fall) begin
            next_st.sda_oe = 1'b0;
            next_st.state = S_WDATA;
          end
        end
        // data bits change only on a falling SCL
        S_RDATA: begin
          if (scl_fall) begin
            if (st.bitcnt == 4'h8) begin
              next_st.sda_oe = 1'b0;
              next_st.state = S_RDATA_ACK;
            end else begin
              next_st.sda_oe = ~st.shreg[7];
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.bitcnt = st.bitcnt + 4'h1;
            end
          end
        end
        S_RDATA_ACK: begin
          if (scl_rise) begin
            next_st.nack = st.sda_s2;
          end else if (scl_fall) begin
            // released SDA after the master's NACK
            if (st.nack) begin
              next_st.state = S_IDLE;
            end else begin
              next_st.sda_oe = ~rd_next[7];
              next_st.shreg = {rd_next[6:0], 1'b0};
              next_st.bitcnt = 4'h1;
              if (st.bytecnt != 2'd3) begin
                next_st.bytecnt = st.bytecnt + 2'd1;
              end
              next_st.state = S_RDATA;
            end
          end
        end
      endcase
    end
  end

  // Pins idle high so the synchronisers start from a released bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
              sda_d: 1'b1, state: S_IDLE, bitcnt: 4'h0, shreg: 8'h00, hold: 8'h00,
              cmd: 8'h00, bytecnt: 2'd0, rw: 1'b0, nack: 1'b0, wrote: 1'b0,
              addr_wrote: 1'b0, commit_reg: 1'b0, commit_cmd: 1'b0, commit_addr: 1'b0,
              sda_oe: 1'b0, sda_out: 1'b0, tuning: `STWRP_RST_TUNING, band: FACTORY_BAND,
              divider: `STWRP_RST_DIVIDER, routing: `STWRP_RST_ROUTING,
              bus_id: `STWRP_RST_BUS_ID};
    end else begin
      st <= next_st;
    end
  end

  stwrp_nv_store #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES),
    .FACTORY_BAND(FACTORY_BAND)
  ) u_nv (
    .clk(clk),
    .rst(rst),
    .commit_reg(st.commit_reg),
    .commit_cmd(st.commit_cmd),
    .commit_addr(st.commit_addr),
    .tuning(st.tuning),
    .band(st.band),
    .divider(st.divider),
    .routing(st.routing),
    .bus_id(st.bus_id),
    .busy(busy),
    .nv_tuning(nv_tuning),
    .nv_band(nv_band),
    .nv_divider(nv_divider),
    .nv_routing(nv_routing),
    .nv_bus_id(nv_bus_id)
  );

  assign sda_out = st.sda_out;
  assign sda_oe = st.sda_oe;
  assign tuning_code = st.tuning;
  assign band_offset = st.band;
  assign divider_word = st.divider;
  assign output_routing_word = st.routing;
  assign bus_id = st.bus_id;
  assign nv_busy = busy;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_start_to_addr: assert property (start_det |=> st.state == S_ADDR && !st.sda_oe)
    else $error("START not followed by address phase");
  a_sda_stable_high: assert property (
    (st.scl_s2 && st.scl_d && !start_det && !stop_det) |=> st.sda_oe == $past(st.sda_oe))
    else $error("SDA drive changed while SCL high");
  a_ack_drives_low: assert property (
    (st.state inside {S_ADDR_ACK, S_CMD_ACK, S_WDATA_ACK}) |-> st.sda_oe)
    else $error("Acknowledge slot not driven low");
  a_busy_nack_addr: assert property (
    (st.state == S_ADDR && scl_fall && st.bitcnt == 4'h8 && busy)
      |=> st.state == S_IDLE && !st.sda_oe ##1 !st.sda_oe)
    else $error("Address acknowledged while store busy");
  a_auto_commit: assert property (
    ((start_det || stop_det) && st.wrote && !commit_on_command)
      |=> st.commit_reg ##1 busy && !st.commit_reg)
    else $error("Automatic commit missing after write");
  a_addr_commit: assert property (((start_det || stop_det) && st.addr_wrote)
    |=> st.commit_addr ##1 busy)
    else $error("Address byte not committed");
  a_cmd_commit: assert property (
    (st.state == S_CMD && scl_fall && st.bitcnt == 4'h8 && st.shreg == `STWRP_CMD_COMMIT
      && commit_on_command) |=> st.commit_cmd && st.state == S_CMD_ACK)
    else $error("Commit command ignored");
  a_no_commit_wc: assert property (
    (commit_on_command && !st.addr_wrote && !(st.state == S_CMD)) |=> !st.commit_reg)
    else $error("Automatic commit while commit_on_command set");
  a_nack_release: assert property (
    (st.state == S_RDATA_ACK && scl_fall && st.nack && !start_det && !stop_det)
      |=> st.state == S_IDLE && !st.sda_oe)
    else $error("SDA not released after master NACK");
  a_tuning_join: assert property (
    (st.state == S_WDATA && scl_fall && st.bitcnt == 4'h8 && st.cmd == `STWRP_CMD_TUNING
      && st.bytecnt == 2'd1) |=> st.tuning == {$past(st.hold), $past(st.shreg[7:6])})
    else $error("Tuning code not assembled from two bytes");
  a_band_readback: assert property (
    (st.state == S_ADDR_ACK && scl_fall && st.rw && st.cmd == `STWRP_CMD_BAND)
      |=> st.shreg[7:6] == 2'b11)
    else $error("Offset upper bits not read as ones");
  a_unknown_ignored: assert property (
    (st.state == S_WDATA && !(st.cmd inside {`STWRP_CMD_TUNING, `STWRP_CMD_DIVIDER,
      `STWRP_CMD_ROUTING, `STWRP_CMD_BAND, `STWRP_CMD_BUS_ID}))
      |=> $stable(st.tuning) && $stable(st.band) && $stable(st.divider) && $stable(st.bus_id))
    else $error("Register changed by unknown command");

  c_write_commit: cover property (st.commit_reg ##[1:20] busy);
  c_read_nack: cover property (st.state == S_RDATA_ACK && st.nack ##[1:200] st.state == S_IDLE);
  c_busy_refuse: cover property (st.state == S_ADDR && scl_fall && st.bitcnt == 4'h8 && busy);
  c_cmd_commit: cover property (st.commit_cmd);
endmodule
`default_nettype wire

// ---- stwrp_bus_master.sv ----
// Behavioural two-wire bus master that drives the register port
`timescale 1ns/1ps
`default_nettype none
module stwrp_bus_master (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    // Eight clocks a bit: a 400 ns bus clock, four clocks low and four high
    scl = 1'b0;
    wait_clk(2);
    sda_low = ~b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(2);
    r = sda;
    wait_clk(2);
  endtask
  task automatic start();
    scl = 1'b0;
    wait_clk(3);
    sda_low = 1'b0;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b1;
    wait_clk(4);
  endtask
  task automatic stop();
    scl = 1'b0;
    wait_clk(3);
    sda_low = 1'b1;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b0;
    wait_clk(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the two-wire register port
`timescale 1ns/1ps
`default_nettype none
`include "stwrp_params.svh"
module testbench import stwrp_pkg::*;;
  logic clk, rst, scl, sda_low, sda, sda_out, sda_oe, nv_busy, ack;
  logic [9:0] tuning_code, divider_word, output_routing_word, nv_tuning, nv_divider, nv_routing;
  logic [4:0] band_offset, bus_id, nv_band, nv_bus_id;
  logic [7:0] rd_b [2];
  logic [6:0] dev;
  int fail_count = 0;
  int cmp_count = 0;
  // Pull-up wins unless someone pulls low
  assign sda = ~(sda_oe | sda_low);
  stwrp_port #(.NV_WRITE_CYCLES(200)) uut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .tuning_code(tuning_code), .band_offset(band_offset),
    .divider_word(divider_word), .output_routing_word(output_routing_word), .bus_id(bus_id),
    .nv_busy(nv_busy), .nv_tuning(nv_tuning), .nv_band(nv_band), .nv_divider(nv_divider),
    .nv_routing(nv_routing), .nv_bus_id(nv_bus_id));
  stwrp_bus_master m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // address, command, data or repeated start and read
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                      input int nw, input int nr);
    logic r;
    m.start();
    m.wbyte({a, 1'b0}, ack);
    if (ack) begin
      m.wbyte(c, r);
      for (int i = 0; i < nw; i++) m.wbyte(i == 0 ? d[15:8] : d[7:0], r);
      if (nr > 0) begin
        m.start();
        m.wbyte({a, 1'b1}, r);
        for (int i = 0; i < nr; i++) m.rbyte(i == nr - 1, rd_b[i]);
      end
    end
    m.stop();
  endtask
  // wait out the store write cycle
  task automatic idle();
    int n = 0;
    repeat (4) @(negedge clk);
    while (nv_busy !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) fail_count++;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs well under a millisecond
  initial begin
    #3000000;
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    dev = {`STWRP_DEV_TYPE, 3'b000};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("bus_id", bus_id, 16'h0);
    check("sda_out", sda_out, 16'h0);
    xfer(dev, 8'h37, 16'h0, 0, 2);
    check("range", {rd_b[0], rd_b[1]}, {`STWRP_FACTORY_BAND, 11'h0});
    $display("test range done");
    xfer(dev, 8'h08, 16'ha5ff, 2, 0);
    check("tuning", tuning_code, 16'h297);
    xfer(dev, 8'h08, 16'h0, 0, 2);
    check("busy ack", ack, 16'h0);
    idle();
    check("nv_tuning", nv_tuning, 16'h297);
    xfer(dev, 8'h08, 16'h0, 0, 2);
    check("tuning read", {rd_b[0], rd_b[1]}, 16'ha5c0);
    xfer(dev, 8'h0e, 16'hf300, 1, 0);
    idle();
    check("nv_band", nv_band, 16'h13);
    check("band_offset", band_offset, 16'h13);
    xfer(dev, 8'h0e, 16'h0, 0, 1);
    check("band read", rd_b[0], 16'hf3);
    $display("test auto commit done");
    xfer(dev, 8'h0d, 16'hea00, 1, 0);
    idle();
    check("nv_bus_id", nv_bus_id, 16'h0a);
    xfer(dev, 8'h0d, 16'h0, 0, 1);
    check("old addr ack", ack, 16'h0);
    xfer({~`STWRP_DEV_TYPE, 3'b010}, 8'h0d, 16'h0, 0, 1);
    check("bad type ack", ack, 16'h0);
    dev = {`STWRP_DEV_TYPE, 3'b010};
    xfer(dev, 8'h0d, 16'h0, 0, 1);
    check("bus_id read", rd_b[0], 16'h0a);
    $display("test address done");
    xfer(dev, 8'h01, 16'h1240, 2, 0);
    xfer(dev, 8'h02, 16'hffff, 2, 0);
    idle();
    check("divider", divider_word, 16'h049);
    check("nv_divider held", nv_divider, 16'h0);
    check("routing", output_routing_word, 16'h3ff);
    xfer(dev, 8'h01, 16'h0, 0, 2);
    check("divider read", {rd_b[0], rd_b[1]}, 16'h1240);
    xfer(dev, 8'h02, 16'h0, 0, 2);
    check("routing read", {rd_b[0], rd_b[1]}, 16'hffc0);
    xfer(dev, 8'h3f, 16'h0, 0, 0);
    idle();
    check("nv_divider", nv_divider, 16'h049);
    check("nv_routing", nv_routing, 16'h3ff);
    $display("test commit command done");
    xfer(dev, 8'h20, 16'h5555, 2, 0);
    idle();
    check("divider kept", divider_word, 16'h049);
    check("tuning kept", tuning_code, 16'h297);
    $display("test unknown command done");
    close_out();
  end
endmodule
`default_nettype wire
